//--- rtl/bcs_params.svh
// Purpose: constants for the battery charge switch sequencer
// Assumes: 100 MHz hclk; times held in ms and converted to cycles
// Notes: register offsets are byte addresses on the AHB-Lite slave
`ifndef BCS_PARAMS_SVH
`define BCS_PARAMS_SVH
`define BCS_CLK_MHZ 100
`define BCS_CYC_PER_MS (`BCS_CLK_MHZ * 1000)
// default times in ms
`define BCS_CYCLE_MS_DEF 16'h03E8
`define BCS_MEAS_MS_DEF 16'h0064
`define BCS_CHG_MS_DEF 16'h1388
`define BCS_P2_OPEN_MS 16'h0064
`define BCS_P2_CLOSED_MS 16'h03E8
`define BCS_P3_CLOSED_MS 16'h03E8
`define BCS_P3_OPEN_MIN_MS 16'h0064
`define BCS_P3_OPEN_MAX_MS 16'h0BB8
// temperature sample rate 216 S/s
`define BCS_TEMP_RATE 216
// register byte offsets
`define BCS_A_CTRL 6'h00
`define BCS_A_CYCLE 6'h04
`define BCS_A_MEAS 6'h08
`define BCS_A_CHG 6'h0C
`define BCS_A_FULL 6'h10
`define BCS_A_PH2 6'h14
`define BCS_A_PH3 6'h18
`define BCS_A_TLIM 6'h1C
`define BCS_A_P3OPEN 6'h20
`define BCS_A_STAT 6'h24
`define BCS_A_IRQ 6'h28
`define BCS_A_MASK 6'h2C
`define BCS_A_MEAS_V 6'h30
// control bits
`define BCS_CTRL_EN 0
`define BCS_CTRL_ALG 1
`define BCS_CTRL_MODON 2
// default limits
`define BCS_FULL_DEF 10'h3FF
`define BCS_TLO_DEF 10'h000
`define BCS_THI_DEF 10'h3FF
// interrupt bits
`define BCS_IRQ_W 4
`define BCS_IRQ_FULL 0
`define BCS_IRQ_PHASE 1
`define BCS_IRQ_TEMP 2
`define BCS_IRQ_PRE 3
`endif

//--- rtl/bcs_pkg.sv
// Purpose: types for the battery charge switch sequencer
// Assumes: one hclk domain
// Notes: states are left to the tool to encode
package bcs_pkg;
	typedef enum logic [2:0] {
		BCS_IDLE,
		BCS_MEASURE,
		BCS_CHARGE,
		BCS_FULL_HOLD,
		BCS_WAIT_CYCLE,
		BCS_LI_OPEN,
		BCS_LI_CLOSED
	} bcs_state_type;
	typedef enum logic [1:0] {
		BCS_PH_CONST,
		BCS_PH_EARLY,
		BCS_PH_LATE
	} bcs_phase_type;
endpackage : bcs_pkg

//--- rtl/bcs_top.sv
// Purpose: charge switch sequencer with AHB-Lite register slave
// Assumes: battery_voltage and temperature come as 10-bit samples from off-domain ADCs
// Notes: all times are in ms, one millisecond tick shared by both algorithms
//
// What this block does
// - algorithm 0 nickel, algorithm 1 lithium
// - algorithm sets switching rate and closed time
// - alg0: open measure time then close charge
// - alg0 full level: keep open one charge
// - cycle, measure, charge, full level configurable
// - alg0 ignores temperature
// - alg1 phases: constant, early pulse, late pulse
// - phase times: closed; 0.1/1; 0.1-3/1
// - temperature supervised only under algorithm 1
// - temperature limits set by command
// - temperature channel 10-bit at 216 S/s
// - precharge only when off, 2.8-3.2 V
//
// Register access over AHB-Lite and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`include "bcs_params.svh"
module bcs_top
	import bcs_pkg::*;
(
	input wire logic hclk, // bus clock
	input wire logic hresetn, // async reset, active low
	input wire logic hsel, // slave select
	input wire logic [31:0] haddr, // byte address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write when high
	input wire logic [2:0] hsize, // transfer size
	input wire logic [31:0] hwdata, // write data
	input wire logic hready, // bus ready
	output logic [31:0] hrdata, // read data
	output logic hreadyout, // slave ready
	output logic hresp, // always okay
	input wire logic [9:0] battery_voltage, // battery level sample, async
	input wire logic [9:0] battery_temp_adc_input, // ntc sample, async
	input wire logic precharge_window, // comparator: 2.8 V < battery_voltage < 3.2 V, async
	output logic charge_switch_closed, // closes charger_input onto supply rail
	output logic precharge_en, // 50 mA constant precharge source
	output logic irq // level interrupt
);
	localparam logic [31:0] MS_CYC = 32'(`BCS_CYC_PER_MS);
	localparam logic [31:0] TS_CYC = 32'((`BCS_CLK_MHZ * 1000000) / `BCS_TEMP_RATE);

	// two-flop synchronisers on the analog side samples
	logic [9:0] vb_s1_ff, vb_ff, tp_s1_ff, tp_raw_ff;
	logic pw_s1_ff, pw_ff;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			vb_s1_ff <= 10'h000;
			vb_ff <= 10'h000;
			tp_s1_ff <= 10'h000;
			tp_raw_ff <= 10'h000;
			pw_s1_ff <= 1'b0;
			pw_ff <= 1'b0;
		end else begin
			vb_s1_ff <= battery_voltage;
			vb_ff <= vb_s1_ff;
			tp_s1_ff <= battery_temp_adc_input;
			tp_raw_ff <= tp_s1_ff;
			pw_s1_ff <= precharge_window;
			pw_ff <= pw_s1_ff;
		end
	end

	// registers
	logic [2:0] ctrl_ff, nxt_ctrl;
	logic [15:0] cyc_ms_ff, nxt_cyc_ms, meas_ms_ff, nxt_meas_ms, chg_ms_ff, nxt_chg_ms;
	logic [15:0] p3open_ms_ff, nxt_p3open_ms;
	logic [9:0] full_ff, nxt_full, ph2_ff, nxt_ph2, ph3_ff, nxt_ph3;
	logic [9:0] tlo_ff, nxt_tlo, thi_ff, nxt_thi;
	logic [`BCS_IRQ_W-1:0] sts_ff, nxt_sts, mask_ff, nxt_mask, ev;
	logic [9:0] meas_v_ff, nxt_meas_v;
	logic [9:0] temp_ff, nxt_temp;
	// AHB address phase capture
	logic wr_pend_ff, nxt_wr_pend;
	logic [5:0] wa_ff, nxt_wa;
	logic [31:0] rd_ff, nxt_rd;
	logic irq_ff, rdy_ff, resp_ff; // every bus and interrupt output comes from a flop

	// clamp open time of the late phase to 0.1..3 s
	function automatic logic [15:0] clamp_p3(input logic [15:0] v);
		if (v < `BCS_P3_OPEN_MIN_MS)
			return `BCS_P3_OPEN_MIN_MS;
		else if (v > `BCS_P3_OPEN_MAX_MS)
			return `BCS_P3_OPEN_MAX_MS;
		else
			return v;
	endfunction : clamp_p3

	// read mux, shared by all reads
	function automatic logic [31:0] rd_mux(input logic [5:0] a);
		unique case (a)
			`BCS_A_CTRL: return {29'h0, ctrl_ff};
			`BCS_A_CYCLE: return {16'h0, cyc_ms_ff};
			`BCS_A_MEAS: return {16'h0, meas_ms_ff};
			`BCS_A_CHG: return {16'h0, chg_ms_ff};
			`BCS_A_FULL: return {22'h0, full_ff};
			`BCS_A_PH2: return {22'h0, ph2_ff};
			`BCS_A_PH3: return {22'h0, ph3_ff};
			`BCS_A_TLIM: return {6'h0, thi_ff, 6'h0, tlo_ff};
			`BCS_A_P3OPEN: return {16'h0, p3open_ms_ff};
			`BCS_A_STAT: return {22'h0, temp_ff};
			`BCS_A_IRQ: return {28'h0, sts_ff};
			`BCS_A_MASK: return {28'h0, mask_ff};
			`BCS_A_MEAS_V: return {22'h0, meas_v_ff};
			default: return 32'h0;
		endcase
	endfunction : rd_mux

	logic addr_ok;
	assign addr_ok = hsel && hready && htrans[1];

	// bus slave: zero wait states, write lands in data phase
	always_comb begin
		nxt_wr_pend = addr_ok && hwrite;
		nxt_wa = addr_ok ? haddr[5:0] : wa_ff;
		nxt_rd = (addr_ok && !hwrite) ? rd_mux(haddr[5:0]) : 32'h0;
		nxt_ctrl = ctrl_ff;
		nxt_cyc_ms = cyc_ms_ff;
		nxt_meas_ms = meas_ms_ff;
		nxt_chg_ms = chg_ms_ff;
		nxt_full = full_ff;
		nxt_ph2 = ph2_ff;
		nxt_ph3 = ph3_ff;
		nxt_tlo = tlo_ff;
		nxt_thi = thi_ff;
		nxt_p3open_ms = p3open_ms_ff;
		nxt_mask = mask_ff;
		nxt_sts = sts_ff;
		if (wr_pend_ff) begin
			unique case (wa_ff)
				`BCS_A_CTRL: nxt_ctrl = hwdata[2:0];
				`BCS_A_CYCLE: nxt_cyc_ms = hwdata[15:0];
				`BCS_A_MEAS: nxt_meas_ms = hwdata[15:0];
				`BCS_A_CHG: nxt_chg_ms = hwdata[15:0];
				`BCS_A_FULL: nxt_full = hwdata[9:0];
				`BCS_A_PH2: nxt_ph2 = hwdata[9:0];
				`BCS_A_PH3: nxt_ph3 = hwdata[9:0];
				`BCS_A_TLIM: begin
					nxt_tlo = hwdata[9:0];
					nxt_thi = hwdata[25:16];
				end
				`BCS_A_P3OPEN: nxt_p3open_ms = clamp_p3(hwdata[15:0]);
				`BCS_A_IRQ: nxt_sts = sts_ff & ~hwdata[`BCS_IRQ_W-1:0];
				`BCS_A_MASK: nxt_mask = hwdata[`BCS_IRQ_W-1:0];
				default: nxt_sts = nxt_sts;
			endcase
		end
		// set wins over a clear in the same cycle
		nxt_sts = nxt_sts | ev;
	end

	// temperature sampler at 216 S/s, used only by algorithm 1
	logic [31:0] tdiv_ff, nxt_tdiv;
	always_comb begin
		nxt_tdiv = (tdiv_ff >= TS_CYC - 32'h1) ? 32'h0 : tdiv_ff + 32'h1;
		nxt_temp = (tdiv_ff == 32'h0) ? tp_raw_ff : temp_ff;
	end

	// millisecond tick
	logic [31:0] msdiv_ff, nxt_msdiv;
	logic ms_tick;
	assign ms_tick = (msdiv_ff == MS_CYC - 32'h1);
	assign nxt_msdiv = ms_tick ? 32'h0 : msdiv_ff + 32'h1;

	// sequencer
	bcs_state_type st_ff, nxt_st;
	bcs_phase_type ph_ff, nxt_ph;
	logic [15:0] t_ff, nxt_t, per_ff, nxt_per;
	logic sw_ff, nxt_sw, pre_ff, nxt_pre;
	logic en, alg_li, mod_on, temp_ok;
	assign en = ctrl_ff[`BCS_CTRL_EN];
	assign alg_li = ctrl_ff[`BCS_CTRL_ALG];
	assign mod_on = ctrl_ff[`BCS_CTRL_MODON];
	assign temp_ok = (temp_ff >= tlo_ff) && (temp_ff <= thi_ff);

	always_comb begin
		nxt_st = st_ff;
		nxt_ph = ph_ff;
		nxt_t = (ms_tick && t_ff != 16'h0) ? t_ff - 16'h1 : t_ff;
		nxt_per = (ms_tick && per_ff != 16'h0) ? per_ff - 16'h1 : per_ff;
		nxt_meas_v = meas_v_ff;
		ev = '0;
		// precharge: hardware only, module off, voltage inside window
		nxt_pre = !mod_on && pw_ff;
		if (nxt_pre && !pre_ff)
			ev[`BCS_IRQ_PRE] = 1'b1;
		if (!en || !mod_on) begin
			nxt_st = BCS_IDLE;
		end else begin
			unique case (st_ff)
				BCS_IDLE: begin
					nxt_ph = BCS_PH_CONST;
					nxt_st = alg_li ? BCS_LI_CLOSED : BCS_MEASURE;
					nxt_t = alg_li ? 16'h0 : meas_ms_ff;
					nxt_per = cyc_ms_ff;
				end
				BCS_MEASURE: if (t_ff == 16'h0) begin
					nxt_meas_v = vb_ff; // sample taken with switch open
					nxt_t = chg_ms_ff;
					if (vb_ff >= full_ff) begin
						nxt_st = BCS_FULL_HOLD;
						ev[`BCS_IRQ_FULL] = 1'b1;
					end else
						nxt_st = BCS_CHARGE;
				end
				BCS_CHARGE, BCS_FULL_HOLD: if (t_ff == 16'h0)
					nxt_st = BCS_WAIT_CYCLE;
				BCS_WAIT_CYCLE: if (per_ff == 16'h0) begin
					// restart on the cycle grid, never early
					nxt_st = BCS_MEASURE;
					nxt_t = meas_ms_ff;
					nxt_per = cyc_ms_ff;
				end
				BCS_LI_CLOSED: if (!temp_ok) begin
					nxt_st = BCS_LI_OPEN;
					nxt_t = `BCS_P2_OPEN_MS;
					ev[`BCS_IRQ_TEMP] = 1'b1;
				end else if (ph_ff == BCS_PH_CONST) begin
					if (vb_ff >= ph2_ff) begin
						nxt_ph = BCS_PH_EARLY;
						ev[`BCS_IRQ_PHASE] = 1'b1;
						nxt_st = BCS_LI_OPEN;
						nxt_t = `BCS_P2_OPEN_MS;
					end
				end else if (t_ff == 16'h0) begin
					nxt_st = BCS_LI_OPEN;
					nxt_meas_v = vb_ff;
					if (ph_ff == BCS_PH_EARLY && vb_ff >= ph3_ff) begin
						nxt_ph = BCS_PH_LATE;
						ev[`BCS_IRQ_PHASE] = 1'b1;
						nxt_t = p3open_ms_ff;
					end else
						nxt_t = (ph_ff == BCS_PH_LATE) ? p3open_ms_ff : `BCS_P2_OPEN_MS;
				end
				BCS_LI_OPEN: if (t_ff == 16'h0 && temp_ok) begin
					nxt_st = BCS_LI_CLOSED;
					nxt_t = (ph_ff == BCS_PH_LATE) ? `BCS_P3_CLOSED_MS : `BCS_P2_CLOSED_MS;
				end else if (t_ff == 16'h0) begin
					nxt_t = `BCS_P2_OPEN_MS; // hold open until back in range
				end
				default: nxt_st = BCS_IDLE;
			endcase
		end
		// switch level follows the state; temperature is not looked at for algorithm 0
		nxt_sw = (nxt_st == BCS_CHARGE) || (nxt_st == BCS_LI_CLOSED);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_ff <= 3'h0;
			cyc_ms_ff <= `BCS_CYCLE_MS_DEF;
			meas_ms_ff <= `BCS_MEAS_MS_DEF;
			chg_ms_ff <= `BCS_CHG_MS_DEF;
			p3open_ms_ff <= `BCS_P3_OPEN_MIN_MS;
			full_ff <= `BCS_FULL_DEF;
			ph2_ff <= `BCS_FULL_DEF;
			ph3_ff <= `BCS_FULL_DEF;
			tlo_ff <= `BCS_TLO_DEF;
			thi_ff <= `BCS_THI_DEF;
			sts_ff <= '0;
			mask_ff <= '0;
			wr_pend_ff <= 1'b0;
			wa_ff <= 6'h00;
			rd_ff <= 32'h0;
			meas_v_ff <= 10'h000;
			temp_ff <= 10'h000;
			tdiv_ff <= 32'h0;
			msdiv_ff <= 32'h0;
			st_ff <= BCS_IDLE;
			ph_ff <= BCS_PH_CONST;
			t_ff <= 16'h0;
			per_ff <= 16'h0;
			sw_ff <= 1'b0;
			pre_ff <= 1'b0;
			irq_ff <= 1'b0;
			rdy_ff <= 1'b1;
			resp_ff <= 1'b0;
		end else begin
			ctrl_ff <= nxt_ctrl;
			cyc_ms_ff <= nxt_cyc_ms;
			meas_ms_ff <= nxt_meas_ms;
			chg_ms_ff <= nxt_chg_ms;
			p3open_ms_ff <= nxt_p3open_ms;
			full_ff <= nxt_full;
			ph2_ff <= nxt_ph2;
			ph3_ff <= nxt_ph3;
			tlo_ff <= nxt_tlo;
			thi_ff <= nxt_thi;
			sts_ff <= nxt_sts;
			mask_ff <= nxt_mask;
			wr_pend_ff <= nxt_wr_pend;
			wa_ff <= nxt_wa;
			rd_ff <= nxt_rd;
			meas_v_ff <= nxt_meas_v;
			temp_ff <= nxt_temp;
			tdiv_ff <= nxt_tdiv;
			msdiv_ff <= nxt_msdiv;
			st_ff <= nxt_st;
			ph_ff <= nxt_ph;
			t_ff <= nxt_t;
			per_ff <= nxt_per;
			sw_ff <= nxt_sw;
			pre_ff <= nxt_pre;
			irq_ff <= |(nxt_sts & nxt_mask);
			rdy_ff <= 1'b1;
			resp_ff <= 1'b0;
		end
	end

	// outputs straight from flops; slave never stalls
	assign hrdata = rd_ff;
	assign hreadyout = rdy_ff;
	assign hresp = resp_ff;
	assign charge_switch_closed = sw_ff;
	assign precharge_en = pre_ff;
	assign irq = irq_ff;
endmodule : bcs_top

//--- verif/bcs_battery.sv
// Purpose: battery, charger and ntc sensor beside the sequencer
// Assumes: bench may force the battery level at any time
// Notes: ntc code is fixed; temperature paths need far longer runs
`timescale 1ns/100ps
module bcs_battery #(
	parameter logic [9:0] TEMP_CODE = 10'h200 // mild battery temperature
) (
	input wire logic hclk, // simulation clock
	input wire logic charge_switch_closed, // charge switch state
	input wire logic precharge_en, // precharge source on
	input wire logic [11:0] set_mv, // battery millivolts to force
	input wire logic set_load, // force set_mv this edge
	output logic [9:0] battery_voltage, // level code, 4 mV a step
	output logic [9:0] battery_temp_adc_input, // ntc code
	output logic precharge_window // window comparator
);
	logic [11:0] mv = 12'hFA0;
	logic [9:0] div = 10'h000;
	// the charger is current limited, so the cell only creeps up while fed
	always @(posedge hclk) begin
		div <= div + 10'h001;
		if (set_load) mv <= set_mv;
		else if ((charge_switch_closed || precharge_en) && div == 10'h3FF) mv <= mv + 12'h001;
	end
	assign battery_voltage = mv[11:2];
	assign battery_temp_adc_input = TEMP_CODE;
	// window seen by the hardware precharge: 2.8 V to 3.2 V exclusive
	assign precharge_window = (mv > 12'hAF0) && (mv < 12'hC80);
endmodule : bcs_battery

//--- verif/bcs_monitor.sv
// Purpose: port checker for the charge switch sequencer
// Assumes: one hclk domain, hresetn async active low
// Notes: ms-timed switching lies beyond short runs; precharge and switch exclusion watched
`timescale 1ns/100ps
module bcs_monitor (
	input wire logic hclk, // clock
	input wire logic hresetn, // reset, active low
	input wire logic hsel, // slave select
	input wire logic [31:0] haddr, // byte address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write when high
	input wire logic hready, // bus ready
	input wire logic [31:0] hrdata, // read data
	input wire logic hreadyout, // slave ready
	input wire logic hresp, // response
	input wire logic precharge_window, // window comparator
	input wire logic charge_switch_closed, // switch state
	input wire logic precharge_en // precharge source
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic rd;
	// a read taken at this edge
	assign rd = hsel && hready && htrans[1] && !hwrite;
	a_ready_high: assert property (hreadyout) else $error("slave stalled");
	a_resp_okay: assert property (!hresp) else $error("error response");
	a_rdata_idle: assert property (!rd |=> hrdata == 32'h00000000)
		else $error("read data outside read phase");
	a_unmapped_zero: assert property (rd && haddr[5:0] >= 6'h34 |=> hrdata == 32'h00000000)
		else $error("unmapped read not zero");
	a_ctrl_spare: assert property (rd && haddr[5:0] == 6'h00 |=> hrdata[31:3] == 29'h0)
		else $error("control spare bits set");
	a_tlim_spare: assert property (rd && haddr[5:0] == 6'h1C |=>
		hrdata[31:26] == 6'h00 && hrdata[15:10] == 6'h00) else $error("limit spare bits set");
	a_irq_spare: assert property (rd && haddr[5:0] == 6'h28 |=> hrdata[31:4] == 28'h0)
		else $error("status spare bits set");
	a_pre_window: assert property (!precharge_window [*6] |-> !precharge_en)
		else $error("precharge outside window");
	a_pre_excl: assert property (precharge_en |-> !charge_switch_closed)
		else $error("switch closed during precharge");
endmodule : bcs_monitor

//--- verif/test_bcs_top.sv
// Purpose: self-checking bench for the charge switch sequencer
// Assumes: zero-wait slave, reads checked from a queue of notes
// Notes: ms-timed steps are only watched over their first few cycles
`timescale 1ns/100ps
`include "bcs_params.svh"
`define CHK(nm, e, s) begin tests_run++; if ((s) !== (e)) begin error_cnt++; \
	$display("Error %s expected %h seen %h", nm, e, s); end end
module test_bcs_top;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h00000000;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'b010;
	logic [31:0] hwdata = 32'h00000000;
	logic [31:0] hrdata, e, r;
	logic hreadyout, hresp, win, sw, pre, irq;
	logic [9:0] bv, bt;
	logic [11:0] set_mv = 12'hFA0;
	logic set_load = 1'b0;
	logic rd_ph = 1'b0;
	logic [31:0] exp_q[$];
	int error_cnt = 0;
	int tests_run = 0;
	int cyc = 0;
	always #5 hclk = ~hclk;
	bcs_top u_bcs_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .battery_voltage(bv),
		.battery_temp_adc_input(bt), .precharge_window(win), .charge_switch_closed(sw),
		.precharge_en(pre), .irq(irq));
	bcs_battery u_bcs_battery (.hclk(hclk), .charge_switch_closed(sw), .precharge_en(pre),
		.set_mv(set_mv), .set_load(set_load), .battery_voltage(bv),
		.battery_temp_adc_input(bt), .precharge_window(win));
	task automatic print_verdict();
		$display("Checks run %0d, errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : print_verdict
	// one word transfer; held until ready is sampled, read data noted
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {26'h0000000, a};
		hwrite <= w;
		@(posedge hclk);
		while (!hreadyout) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		if (!w) exp_q.push_back(d);
		@(posedge hclk);
		while (!hreadyout) @(posedge hclk);
	endtask : bus
	// bounded wait for irq (which=1) or precharge_en (which=0) to reach v
	task automatic wait_out(input logic which, input logic v);
		for (int i = 0; i < 16; i++) begin
			if ((which ? irq : pre) === v) break;
			@(posedge hclk);
		end
	endtask : wait_out
	// read data is judged in its data phase against the oldest note
	always @(posedge hclk) begin
		if (rd_ph && hreadyout) begin
			e = exp_q.pop_front();
			`CHK("hrdata", e, hrdata)
		end
		if (hreadyout) rd_ph <= hsel && htrans[1] && !hwrite;
	end
	// hang guard, far above the few hundred cycles the run needs
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			print_verdict();
		end
	end
	initial begin
		void'($urandom(32'h548DC554));
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(0, `BCS_A_CTRL, 32'h00000000);
		bus(0, `BCS_A_CYCLE, {16'h0000, `BCS_CYCLE_MS_DEF});
		bus(0, `BCS_A_MEAS, {16'h0000, `BCS_MEAS_MS_DEF});
		bus(0, `BCS_A_CHG, {16'h0000, `BCS_CHG_MS_DEF});
		bus(0, `BCS_A_FULL, {22'h000000, `BCS_FULL_DEF});
		bus(0, `BCS_A_TLIM, {6'h00, `BCS_THI_DEF, 6'h00, `BCS_TLO_DEF});
		bus(0, `BCS_A_IRQ, 32'h00000000);
		// back-to-back writes then reads, both algorithm codes, unmapped hole
		for (int i = 0; i < 4; i++) begin
			r = $urandom;
			bus(1, `BCS_A_CYCLE, {16'h0000, r[15:0]});
			bus(1, `BCS_A_CHG, {16'h0000, r[31:16]});
			bus(1, `BCS_A_FULL, {22'h000000, r[25:16]});
			bus(1, `BCS_A_TLIM, {6'h00, r[9:0], 6'h00, r[31:22]});
			bus(1, `BCS_A_CTRL, {30'h00000000, i[0], 1'b0});
			bus(1, 6'h38, r);
			bus(0, `BCS_A_CYCLE, {16'h0000, r[15:0]});
			bus(0, `BCS_A_CHG, {16'h0000, r[31:16]});
			bus(0, `BCS_A_FULL, {22'h000000, r[25:16]});
			bus(0, `BCS_A_TLIM, {6'h00, r[9:0], 6'h00, r[31:22]});
			bus(0, `BCS_A_CTRL, {30'h00000000, i[0], 1'b0});
			bus(0, 6'h38, 32'h00000000);
		end
		bus(1, `BCS_A_CTRL, 32'h00000000);
		// module off and cell inside the window: hardware precharge starts
		set_mv <= 12'hBB8;
		set_load <= 1'b1;
		@(posedge hclk);
		set_load <= 1'b0;
		wait_out(0, 1'b1);
		`CHK("precharge_en", 1'b1, pre)
		bus(0, `BCS_A_IRQ, 32'h00000008);
		`CHK("irq masked", 1'b0, irq)
		bus(1, `BCS_A_MASK, 32'h00000008);
		wait_out(1, 1'b1);
		`CHK("irq", 1'b1, irq)
		bus(1, `BCS_A_IRQ, 32'h00000008);
		wait_out(1, 1'b0);
		`CHK("irq cleared", 1'b0, irq)
		// module on forbids precharge even inside the window
		bus(1, `BCS_A_CTRL, 32'h00000004);
		wait_out(0, 1'b0);
		`CHK("precharge_en on", 1'b0, pre)
		bus(1, `BCS_A_CTRL, 32'h00000000);
		wait_out(1, 1'b1);
		`CHK("irq restart", 1'b1, irq)
		set_mv <= 12'hDAC;
		set_load <= 1'b1;
		@(posedge hclk);
		set_load <= 1'b0;
		wait_out(0, 1'b0);
		`CHK("precharge_en high cell", 1'b0, pre)
		// algorithm 1: phase one closes at once, inverted limits open it
		bus(1, `BCS_A_IRQ, 32'h0000000F);
		bus(1, `BCS_A_TLIM, {6'h00, 10'h3FF, 6'h00, 10'h000});
		bus(1, `BCS_A_CTRL, 32'h00000007);
		repeat (4) @(posedge hclk);
		`CHK("switch phase one", 1'b1, sw)
		bus(1, `BCS_A_TLIM, {6'h00, 10'h000, 6'h00, 10'h3FF});
		repeat (4) @(posedge hclk);
		`CHK("switch hot", 1'b0, sw)
		bus(0, `BCS_A_IRQ, 32'h00000004);
		// back in range, then the phase two threshold is crossed
		bus(1, `BCS_A_CTRL, 32'h00000000);
		bus(1, `BCS_A_TLIM, {6'h00, 10'h3FF, 6'h00, 10'h000});
		bus(1, `BCS_A_IRQ, 32'h0000000F);
		bus(1, `BCS_A_CTRL, 32'h00000007);
		bus(1, `BCS_A_PH2, 32'h00000000);
		repeat (4) @(posedge hclk);
		`CHK("switch phase two", 1'b0, sw)
		bus(0, `BCS_A_IRQ, 32'h00000002);
		// algorithm 0 charges although the limits are inverted again
		bus(1, `BCS_A_CTRL, 32'h00000000);
		bus(1, `BCS_A_TLIM, {6'h00, 10'h000, 6'h00, 10'h3FF});
		bus(1, `BCS_A_MEAS, 32'h00000000);
		bus(1, `BCS_A_FULL, 32'h000003FF);
		bus(1, `BCS_A_CHG, 32'h00000001);
		bus(1, `BCS_A_CTRL, 32'h00000005);
		repeat (4) @(posedge hclk);
		`CHK("switch nickel", 1'b1, sw)
		bus(0, `BCS_A_MEAS_V, {22'h000000, 10'h36B});
		// a cell at the full level is held open and flagged
		bus(1, `BCS_A_CTRL, 32'h00000000);
		bus(1, `BCS_A_FULL, 32'h00000000);
		bus(1, `BCS_A_IRQ, 32'h0000000F);
		bus(1, `BCS_A_CTRL, 32'h00000005);
		repeat (4) @(posedge hclk);
		`CHK("switch full", 1'b0, sw)
		bus(0, `BCS_A_IRQ, 32'h00000001);
		print_verdict();
	end
endmodule : test_bcs_top
bind bcs_top bcs_monitor u_bcs_monitor (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .precharge_window(precharge_window),
	.charge_switch_closed(charge_switch_closed), .precharge_en(precharge_en));
